/* mpp_port_pins.sv */
// Pin logic for ports A, B, C, E, G and H with alternate functions.
// Assumes pins are resolved outside from o/oe; peripherals run on clk.
//
// Notes on behaviour
// - Port A has eight lines, each with its own direction bit.
// - Port B bits 0-6 have own direction bits; bit 7 is output only.
// - Port E bits 0-5 are inputs only and bits 6-7 outputs only.
// - Port G bits 0-3 merge port data with the pulse pattern output.
// - All direction bits reset to input, so bidirectional pins float after reset.
// - The serial 1 data pin resets with select and data at one, driving the serial 1 data output.
// - Serial 0 clock, serial 1 clock and serial 0 data selects reset to port mode.
// - Port E bit 7 picks timer, duty detect, high or low adjust by a 2-bit code.
// - Adjust outputs divide the 32 kHz oscillator; the low one can drive a buzzer.
// - Port C inputs are offered as key return lines for the display scan.
// - Port A analog selects reset to zero, leaving digital port mode.
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module mpp_port_pins (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register port
	input wire logic [mpp_pkg::AW-1:0] addr,
	input wire logic [mpp_pkg::W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [mpp_pkg::W-1:0] rdata,
	// Port A
	input wire logic [7:0] pa_i,
	output logic [7:0] pa_o,
	output logic [7:0] pa_oe,
	output logic [7:0] analog_input_line,
	// Port B
	input wire logic [7:0] pb_i,
	output logic [7:0] pb_o,
	output logic [7:0] pb_oe,
	output logic [6:0] pb_sync,
	// Serial outputs
	input wire logic serial0_clock,
	input wire logic serial0_data_out,
	input wire logic serial1_clock,
	input wire logic serial1_data_out,
	// Port C
	input wire logic [7:0] pc_i,
	output logic [7:0] pc_o,
	output logic [7:0] pc_oe,
	output logic [7:0] key_return_line,
	// Port E
	input wire logic [5:0] pe_i,
	output logic [5:0] pe_sync,
	output logic [1:0] pe_hi_o,
	input wire logic pwm_out,
	input wire logic timer_square_wave,
	input wire logic duty_detect_output,
	input wire logic osc32_in,
	output logic osc_adjust_high_divide,
	output logic osc_adjust_low_divide,
	// Port G
	input wire logic [7:0] pg_i,
	output logic [7:0] pg_o,
	output logic [7:0] pg_oe,
	input wire logic [3:0] pulse_pattern_output,
	// Port H
	input wire logic [7:0] ph_i,
	output logic [7:0] ph_o,
	output logic [7:0] ph_oe
);
	import mpp_pkg::*;

	typedef struct packed {
		logic [7:0] a_dat;
		logic [7:0] a_dir;
		logic [7:0] a_ana;
		logic [7:0] b_dat;
		logic [7:0] b_dir;
		logic [7:0] b_sel;
		logic [7:0] c_dat;
		logic [7:0] c_dir;
		logic [1:0] e_dat;
		logic [1:0] e_sel;
		logic [7:0] g_dat;
		logic [7:0] g_dir;
		logic [3:0] g_rto;
		logic [7:0] h_dat;
		logic [7:0] h_dir;
		logic [7:0] a_s1;
		logic [7:0] a_s2;
		logic [7:0] b_s1;
		logic [7:0] b_s2;
		logic [7:0] c_s1;
		logic [7:0] c_s2;
		logic [5:0] e_s1;
		logic [5:0] e_s2;
		logic [7:0] g_s1;
		logic [7:0] g_s2;
		logic [7:0] h_s1;
		logic [7:0] h_s2;
		logic osc_s1;
		logic osc_s2;
		logic osc_prev;
		logic [3:0] adj;
		logic [7:0] rdat;
	} mpp_state_t;

	mpp_state_t s_ff;
	mpp_state_t nxt_s;
	logic e7_src;

	function automatic logic [7:0] mpp_rb(input logic [7:0] dat,
		input logic [7:0] dir, input logic [7:0] pin);
		mpp_rb = (dir & dat) | (~dir & pin);
	endfunction : mpp_rb

	always_comb begin
		nxt_s = s_ff;
		// Two-stage pin synchronisers
		nxt_s.a_s1 = pa_i;
		nxt_s.a_s2 = s_ff.a_s1;
		nxt_s.b_s1 = pb_i;
		nxt_s.b_s2 = s_ff.b_s1;
		nxt_s.c_s1 = pc_i;
		nxt_s.c_s2 = s_ff.c_s1;
		nxt_s.e_s1 = pe_i;
		nxt_s.e_s2 = s_ff.e_s1;
		nxt_s.g_s1 = pg_i;
		nxt_s.g_s2 = s_ff.g_s1;
		nxt_s.h_s1 = ph_i;
		nxt_s.h_s2 = s_ff.h_s1;
		nxt_s.osc_s1 = osc32_in;
		nxt_s.osc_s2 = s_ff.osc_s1;
		nxt_s.osc_prev = s_ff.osc_s2;
		// Oscillator divider, one step per rising edge
		if (s_ff.osc_s2 && !s_ff.osc_prev) begin
			nxt_s.adj = s_ff.adj + 4'h1;
		end
		if (wr) begin
			case (addr)
				OFS_A_DAT: nxt_s.a_dat = wdata;
				OFS_A_DIR: nxt_s.a_dir = wdata;
				OFS_A_ANA: nxt_s.a_ana = wdata;
				OFS_B_DAT: nxt_s.b_dat = wdata;
				OFS_B_DIR: nxt_s.b_dir = {1'b0, wdata[6:0]};
				OFS_B_SEL: nxt_s.b_sel = wdata;
				OFS_C_DAT: nxt_s.c_dat = wdata;
				OFS_C_DIR: nxt_s.c_dir = wdata;
				OFS_E_DAT: nxt_s.e_dat = wdata[7:6];
				OFS_E_SEL: nxt_s.e_sel = wdata[1:0];
				OFS_G_DAT: nxt_s.g_dat = wdata;
				OFS_G_DIR: nxt_s.g_dir = wdata;
				OFS_G_RTO: nxt_s.g_rto = wdata[3:0];
				OFS_H_DAT: nxt_s.h_dat = wdata;
				OFS_H_DIR: nxt_s.h_dir = wdata;
				default: ;
			endcase
		end
		// Read data, valid the cycle after the strobe
		nxt_s.rdat = RST_ZERO;
		if (rd) begin
			case (addr)
				OFS_A_DAT: nxt_s.rdat = mpp_rb(s_ff.a_dat, s_ff.a_dir,
					s_ff.a_s2 & ~s_ff.a_ana);
				OFS_A_DIR: nxt_s.rdat = s_ff.a_dir;
				OFS_A_ANA: nxt_s.rdat = s_ff.a_ana;
				OFS_B_DAT: nxt_s.rdat = mpp_rb(s_ff.b_dat,
					s_ff.b_dir | 8'h80, s_ff.b_s2);
				OFS_B_DIR: nxt_s.rdat = s_ff.b_dir;
				OFS_B_SEL: nxt_s.rdat = s_ff.b_sel;
				OFS_C_DAT: nxt_s.rdat = mpp_rb(s_ff.c_dat, s_ff.c_dir, s_ff.c_s2);
				OFS_C_DIR: nxt_s.rdat = s_ff.c_dir;
				OFS_E_DAT: nxt_s.rdat = {s_ff.e_dat, s_ff.e_s2};
				OFS_E_SEL: nxt_s.rdat = {6'h00, s_ff.e_sel};
				OFS_G_DAT: nxt_s.rdat = mpp_rb(s_ff.g_dat, s_ff.g_dir, s_ff.g_s2);
				OFS_G_DIR: nxt_s.rdat = s_ff.g_dir;
				OFS_G_RTO: nxt_s.rdat = {4'h0, s_ff.g_rto};
				OFS_H_DAT: nxt_s.rdat = mpp_rb(s_ff.h_dat, s_ff.h_dir, s_ff.h_s2);
				OFS_H_DIR: nxt_s.rdat = s_ff.h_dir;
				default: nxt_s.rdat = RST_ZERO;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_ff <= '0;
			s_ff.a_dir <= RST_DIR;
			s_ff.b_dir <= RST_DIR;
			s_ff.c_dir <= RST_DIR;
			s_ff.g_dir <= RST_DIR;
			s_ff.h_dir <= RST_DIR;
			s_ff.a_ana <= RST_ZERO;
			s_ff.b_dat <= RST_B_DAT;
			s_ff.b_sel <= RST_B_SEL;
			s_ff.e_dat <= RST_E_DAT;
			s_ff.adj <= RST_ADJ;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Port E bit 7 source select
	always_comb begin
		case (mpp_e7_src_t'(s_ff.e_sel))
			SRC_TIMER: e7_src = timer_square_wave;
			SRC_DUTY: e7_src = duty_detect_output;
			SRC_ADJ_HI: e7_src = s_ff.adj[ADJ_HI_BIT];
			SRC_ADJ_LO: e7_src = s_ff.adj[ADJ_LO_BIT];
			default: e7_src = timer_square_wave;
		endcase
	end

	assign rdata = s_ff.rdat;
	assign pa_o = s_ff.a_dat;
	assign pa_oe = s_ff.a_dir & ~s_ff.a_ana;
	assign analog_input_line = s_ff.a_ana;
	assign pb_sync = s_ff.b_s2[6:0];
	assign pc_o = s_ff.c_dat;
	assign pc_oe = s_ff.c_dir;
	assign key_return_line = s_ff.c_s2;
	assign pe_sync = s_ff.e_s2;
	assign pe_hi_o = {s_ff.e_dat[1] & e7_src, s_ff.e_dat[0] & pwm_out};
	assign osc_adjust_high_divide = s_ff.adj[ADJ_HI_BIT];
	assign osc_adjust_low_divide = s_ff.adj[ADJ_LO_BIT];
	assign ph_o = s_ff.h_dat;
	assign ph_oe = s_ff.h_dir;
	assign pg_oe = s_ff.g_dir;
	assign pg_o = {s_ff.g_dat[7:4],
		s_ff.g_dat[3:0] | (s_ff.g_rto & pulse_pattern_output)};

	// Port B: serial functions override port data on selected bits
	generate
		for (genvar i = 0; i < 8; i++) begin : g_pb
			if (i == BIT_SERIAL0_CLOCK || i == BIT_SO0 || i == BIT_SERIAL1_CLOCK) begin : g_alt
				logic alt;
				assign alt = (i == BIT_SERIAL0_CLOCK) ? serial0_clock :
					(i == BIT_SO0) ? serial0_data_out : serial1_clock;
				assign pb_o[i] = s_ff.b_sel[i] ? alt : s_ff.b_dat[i];
				assign pb_oe[i] = s_ff.b_sel[i] | s_ff.b_dir[i];
			end else if (i == BIT_SO1) begin : g_out
				assign pb_o[i] = s_ff.b_sel[i] ? serial1_data_out : s_ff.b_dat[i];
				assign pb_oe[i] = 1'b1;
			end else begin : g_io
				assign pb_o[i] = s_ff.b_dat[i];
				assign pb_oe[i] = s_ff.b_dir[i];
			end
		end
	endgenerate

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	sequence s_wr_adir;
		wr && addr == OFS_A_DIR;
	endsequence
	sequence s_wr_bdir;
		wr && addr == OFS_B_DIR;
	endsequence
	sequence s_rd_a_out;
		rd && addr == OFS_A_DAT && pa_oe == 8'hFF;
	endsequence

	property p_a_dir;
		s_wr_adir |=> pa_oe == ($past(wdata) & ~analog_input_line);
	endproperty
	a_a_dir: assert property (p_a_dir) else $error("port A direction wrong");

	property p_b_dir;
		s_wr_bdir |=> pb_oe[7] && (pb_oe[6] == $past(wdata[6]));
	endproperty
	a_b_dir: assert property (p_b_dir) else $error("port B direction wrong");

	property p_e_read;
		rd && addr == OFS_E_DAT |=>
			rdata[5:0] == $past(pe_sync) && rdata[7:6] == $past(s_ff.e_dat);
	endproperty
	a_e_read: assert property (p_e_read) else $error("port E read wrong");

	property p_rto;
		s_ff.g_rto[0] && pulse_pattern_output[0] |-> pg_o[0];
	endproperty
	a_rto: assert property (p_rto) else $error("pulse output not merged");

	property p_rst_dir;
		$rose(rstn) |-> pa_oe == 8'h00 && pc_oe == 8'h00 && pg_oe == 8'h00
			&& ph_oe == 8'h00 && pb_oe[6:0] == 7'h00;
	endproperty
	a_rst_dir: assert property (p_rst_dir) else $error("pin driven after reset");

	property p_rst_so1;
		$rose(rstn) |-> pb_o[7] == serial1_data_out && pb_oe[7];
	endproperty
	a_rst_so1: assert property (p_rst_so1) else $error("serial 1 pin not selected");

	property p_rst_sel;
		$rose(rstn) |-> s_ff.b_sel[6:0] == 7'h00;
	endproperty
	a_rst_sel: assert property (p_rst_sel) else $error("serial select not reset");

	property p_e7;
		s_ff.e_sel == SRC_ADJ_LO && s_ff.e_dat[1] |-> pe_hi_o[1] == osc_adjust_low_divide;
	endproperty
	a_e7: assert property (p_e7) else $error("port E7 source wrong");

	property p_adj;
		$changed(osc_adjust_low_divide) |-> $changed(osc_adjust_high_divide);
	endproperty
	a_adj: assert property (p_adj) else $error("adjust divider out of step");

	property p_key;
		$past(rstn) && $past(rstn, 2) |-> key_return_line == $past(pc_i, 2);
	endproperty
	a_key: assert property (p_key) else $error("key return not synchronised");

	property p_rst_ana;
		$rose(rstn) |-> analog_input_line == 8'h00;
	endproperty
	a_rst_ana: assert property (p_rst_ana) else $error("analog select not reset");

	property p_rd_out;
		s_rd_a_out |=> rdata == $past(pa_o);
	endproperty
	a_rd_out: assert property (p_rd_out) else $error("output latch not read back");

endmodule : mpp_port_pins
`default_nettype wire

/* mpp_pkg.sv */
// Constants for the multiplexed port pin block.
// Assumes an 8-bit register port on the system clock.
package mpp_pkg;
	localparam int W = 8;
	localparam int AW = 8;
	// Register offsets
	localparam logic [7:0] OFS_A_DAT = 8'h00;
	localparam logic [7:0] OFS_A_DIR = 8'h01;
	localparam logic [7:0] OFS_A_ANA = 8'h02;
	localparam logic [7:0] OFS_B_DAT = 8'h03;
	localparam logic [7:0] OFS_B_DIR = 8'h04;
	localparam logic [7:0] OFS_B_SEL = 8'h05;
	localparam logic [7:0] OFS_C_DAT = 8'h06;
	localparam logic [7:0] OFS_C_DIR = 8'h07;
	localparam logic [7:0] OFS_E_DAT = 8'h08;
	localparam logic [7:0] OFS_E_SEL = 8'h09;
	localparam logic [7:0] OFS_G_DAT = 8'h0A;
	localparam logic [7:0] OFS_G_DIR = 8'h0B;
	localparam logic [7:0] OFS_G_RTO = 8'h0C;
	localparam logic [7:0] OFS_H_DAT = 8'h0D;
	localparam logic [7:0] OFS_H_DIR = 8'h0E;
	// Field positions
	localparam int BIT_SERIAL0_CLOCK = 2;
	localparam int BIT_SO0 = 4;
	localparam int BIT_SERIAL1_CLOCK = 5;
	localparam int BIT_SO1 = 7;
	localparam int ADJ_HI_BIT = 0;
	localparam int ADJ_LO_BIT = 3;
	// Reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_DIR = 8'h00;
	localparam logic [7:0] RST_B_DAT = 8'h80;
	localparam logic [7:0] RST_B_SEL = 8'h80;
	localparam logic [1:0] RST_E_DAT = 2'h3;
	localparam logic [3:0] RST_ADJ = 4'h0;
	// Port E bit 7 sources
	typedef enum logic [1:0] {
		SRC_TIMER = 2'h0,
		SRC_DUTY = 2'h1,
		SRC_ADJ_HI = 2'h2,
		SRC_ADJ_LO = 2'h3
	} mpp_e7_src_t;
endpackage : mpp_pkg

/* mpp_pin_world.sv */
// Outside circuitry on one 8-pin port: resolves the pin level.
// Assumes the bench supplies a fresh drive pattern for undriven pins.
`timescale 1ns/1ps
`default_nettype none
module mpp_pin_world (
	// Device side
	input wire logic [7:0] o,
	input wire logic [7:0] oe,
	// Outside drive and pin level
	input wire logic [7:0] ext,
	output logic [7:0] pin
);
	// Device wins where enabled, outside drive elsewhere
	assign pin = (oe & o) | (~oe & ext);
endmodule : mpp_pin_world
`default_nettype wire

/* multiplexed_port_pin_logic_tb.sv */
// Random and corner tests of the port pin block.
// Assumes mpp_pkg and mpp_port_pins; pins resolved by mpp_pin_world.
`timescale 1ns/1ps
`default_nettype none
module multiplexed_port_pin_logic_tb;
	import mpp_pkg::*;
	logic clk = 0, rstn = 0, wr = 0, rd = 0, osc = 0;
	logic s0c = 0, s0d = 0, s1c = 0, s1d = 0, pwm = 0, tsw = 0, duty = 0, adj_h, adj_l;
	logic [7:0] addr = 0, wdata = 0, rdata, ana, krl;
	logic [7:0] pa_i, pa_o, pa_oe, pb_i, pb_o, pb_oe, pc_i, pc_o, pc_oe;
	logic [7:0] pg_i, pg_o, pg_oe, ph_i, ph_o, ph_oe;
	logic [7:0] ext [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0] ofs_dat [5] = '{OFS_A_DAT, OFS_B_DAT, OFS_C_DAT, OFS_G_DAT, OFS_H_DAT};
	logic [7:0] ofs_dir [5] = '{OFS_A_DIR, OFS_B_DIR, OFS_C_DIR, OFS_G_DIR, OFS_H_DIR};
	logic [6:0] pb_sync;
	logic [5:0] pe_i = 0, pe_sync;
	logic [1:0] pe_hi_o;
	logic [3:0] ppo = 0;
	logic [31:0] seed = 71;
	int mismatches = 0, compares = 0, oscn = 0;
	mpp_port_pins i_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .pa_i(pa_i), .pa_o(pa_o), .pa_oe(pa_oe), .analog_input_line(ana),
		.pb_i(pb_i), .pb_o(pb_o), .pb_oe(pb_oe), .pb_sync(pb_sync), .serial0_clock(s0c),
		.serial0_data_out(s0d), .serial1_clock(s1c), .serial1_data_out(s1d), .pc_i(pc_i),
		.pc_o(pc_o), .pc_oe(pc_oe), .key_return_line(krl), .pe_i(pe_i), .pe_sync(pe_sync),
		.pe_hi_o(pe_hi_o), .pwm_out(pwm), .timer_square_wave(tsw), .duty_detect_output(duty),
		.osc32_in(osc), .osc_adjust_high_divide(adj_h), .osc_adjust_low_divide(adj_l),
		.pg_i(pg_i), .pg_o(pg_o), .pg_oe(pg_oe), .pulse_pattern_output(ppo), .ph_i(ph_i),
		.ph_o(ph_o), .ph_oe(ph_oe));
	mpp_pin_world u_wa (.o(pa_o), .oe(pa_oe), .ext(ext[0]), .pin(pa_i));
	mpp_pin_world u_wb (.o(pb_o), .oe(pb_oe), .ext(ext[1]), .pin(pb_i));
	mpp_pin_world u_wc (.o(pc_o), .oe(pc_oe), .ext(ext[2]), .pin(pc_i));
	mpp_pin_world u_wg (.o(pg_o), .oe(pg_oe), .ext(ext[3]), .pin(pg_i));
	mpp_pin_world u_wh (.o(ph_o), .oe(ph_oe), .ext(ext[4]), .pin(ph_i));
	initial begin
		forever #25 clk = ~clk;
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	function automatic logic [7:0] exp_dat(logic [7:0] d, logic [7:0] l, logic [7:0] p);
		return (d & l) | (~d & p);
	endfunction : exp_dat
	function automatic logic src_val(logic [1:0] s);
		logic [3:0] c;
		c = oscn[3:0];
		case (s)
			2'h0: return tsw;
			2'h1: return duty;
			2'h2: return c[0];
			default: return c[3];
		endcase
	endfunction : src_val
	function automatic logic [23:0] port_v(int p);
		case (p)
			0: return {pa_o, pa_oe, pa_i};
			1: return {pb_o, pb_oe, pb_i};
			2: return {pc_o, pc_oe, pc_i};
			3: return {pg_o, pg_oe, pg_i};
			default: return {ph_o, ph_oe, ph_i};
		endcase
	endfunction : port_v
	task automatic chk(string n, logic [39:0] s, logic [39:0] e);
		compares++;
		if (s !== e) begin
			$display("MISMATCH %s exp %h seen %h", n, e, s);
			mismatches++;
		end
	endtask : chk
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic wr_reg(logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask : rd_reg
	task automatic close_out();
		if (mismatches == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : close_out
	task automatic do_reset();
		logic [7:0] v;
		@(posedge clk);
		rstn <= 1'b0;
		osc <= 1'b0;
		oscn = 0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		tick(1);
		chk("oe_rst", {pa_oe, pb_oe, pc_oe, pg_oe, ph_oe}, 40'h0080000000);
		chk("b7_rst", pb_o[7], s1d);
		chk("ana_rst", ana, 0);
		chk("ehi_rst", pe_hi_o, {tsw, pwm});
		rd_reg(OFS_B_SEL, v);
		chk("bsel_rst", v, 8'h80);
		rd_reg(OFS_E_SEL, v);
		chk("esel_rst", v, 0);
		rd_reg(OFS_B_DAT, v);
		chk("bdat7_rst", v[7], 1'b1);
		rd_reg(8'hFF, v);
		chk("unmapped", v, 0);
	endtask : do_reset
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		close_out();
	end
	initial begin
		logic [7:0] d, l, an, de, om, v, r;
		logic [23:0] pv;
		do_reset();
		for (int it = 0; it < 6; it++) begin
			if (it == 3) do_reset();
			for (int p = 0; p < 5; p++) begin
				d = xs();
				l = xs();
				an = (p == 0) ? (xs() & ~d) : 8'h00;
				wr_reg(ofs_dir[p], d);
				wr_reg(ofs_dat[p], l);
				if (p == 0) wr_reg(OFS_A_ANA, an);
				ext[p] <= xs();
				tick(4);
				de = (p == 1) ? {1'b1, d[6:0]} : d;
				om = (p == 1) ? 8'h7F : 8'hFF;
				pv = port_v(p);
				chk("oe", pv[15:8], de);
				chk("out", pv[23:16] & om, l & om);
				rd_reg(ofs_dat[p], v);
				chk("dat", v, exp_dat(de, l, pv[7:0]) & ~an);
				rd_reg(ofs_dir[p], v);
				chk("dir", v, d & om);
				if (p == 0) chk("ana", ana, an);
				if (p == 1) chk("bsync", pb_sync, pb_i[6:0]);
				if (p == 2) chk("keys", krl, pc_i);
			end
		end
		wr_reg(OFS_A_ANA, 8'h00);
		wr_reg(OFS_A_DIR, 8'hFF);
		l = xs();
		wr_reg(OFS_A_DAT, l);
		rd_reg(OFS_A_DAT, v);
		chk("a_out", v, l);
		wr_reg(OFS_A_ANA, 8'h0F);
		tick(1);
		chk("ana_oe", pa_oe, 8'hF0);
		wr_reg(OFS_G_RTO, 8'h05);
		for (int k = 0; k < 4; k++) begin
			l = xs();
			r = xs();
			wr_reg(OFS_G_DAT, l);
			ppo <= r[3:0];
			tick(1);
			chk("gmerge", pg_o, {l[7:4], l[3:0] | (ppo & 4'h5)});
		end
		wr_reg(OFS_B_SEL, 8'hB4);
		for (int k = 0; k < 4; k++) begin
			r = xs();
			@(posedge clk);
			{s1d, s1c, s0d, s0c} <= r[3:0];
			tick(2);
			chk("bsel_oe", pb_oe & 8'hB4, 8'hB4);
			chk("bsel_o", pb_o & 8'hB4, {r[3], 1'b0, r[2], r[1], 1'b0, r[0], 2'h0});
		end
		for (int k = 1; k < 11; k++) begin
			@(posedge clk);
			osc <= 1'b1;
			tick(4);
			oscn++;
			@(posedge clk);
			osc <= 1'b0;
			tick(4);
			chk("adjust", {adj_l, adj_h}, {oscn[3], oscn[0]});
		end
		l = xs() | 8'h80;
		wr_reg(OFS_E_DAT, l);
		for (int k = 0; k < 4; k++) begin
			r = xs();
			wr_reg(OFS_E_SEL, k[7:0]);
			{pwm, tsw, duty} <= r[2:0];
			pe_i <= r[7:2];
			tick(4);
			chk("ehi", pe_hi_o, {l[7] & src_val(k[1:0]), l[6] & pwm});
			chk("esync", pe_sync, pe_i);
			rd_reg(OFS_E_SEL, v);
			chk("esel", v, k[7:0]);
			rd_reg(OFS_E_DAT, v);
			chk("edat", v, {l[7:6], pe_i});
		end
		close_out();
	end
endmodule : multiplexed_port_pin_logic_tb
`default_nettype wire
